/* dv/far_side_model.sv */
/*
 Far-side model: external oscillator and comparator output.
 Assumes the bench drives oscEn and compReq; both outputs are asynchronous to clk.
*/
`timescale 1ns/1ps
module far_side_model #(
	parameter real OSC_HALF_NS = 37.3
) (
	input wire logic oscEn,
	input wire logic compReq,
	output logic extOsc,
	output logic comparatorOut
);
	// ----------------------------------------------------------------
	// Oscillator stands low outside bursts; slow comparator edges
	// ----------------------------------------------------------------
	initial extOsc = 1'b0;
	initial comparatorOut = 1'b0;
	always begin
		#(OSC_HALF_NS);
		extOsc = oscEn ? ~extOsc : 1'b0;
	end
	always @(compReq) comparatorOut <= #3 compReq;
endmodule

/* dv/tb_autoreload_timer_with_capture.sv */
/*
 Self-checking bench for the timer: AXI4-Lite register tasks and mode scenarios.
 Assumes the far-side model supplies extOsc and comparatorOut.
*/
`timescale 1ns/1ps
module tb_autoreload_timer_with_capture;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic oscEn = 1'b0;
	logic compReq = 1'b0;
	logic extOsc, comparatorOut, timerIrq;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata;
	logic [7:0] rd;
	int failures = 0;
	int checked = 0;
	always #5 clk = ~clk;
	autoreload_timer_with_capture uut (.clk, .sys_rst, .extOsc, .comparatorOut, .timerIrq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	far_side_model farSide (.oscEn, .compReq, .extOsc, .comparatorOut);
	// ----------------------------------------------------------------
	// Bus tasks and checks
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("Counts: %0d compares, %0d mismatches", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic bump(inout int n);
		n++;
		if (n > 600) begin
			failures++;
			end_of_test();
		end
	endtask
	task automatic regWrite(input logic [11:0] a, input logic [7:0] d);
		logic hitA, hitW, hitB, doneA, doneW;
		int n;
		doneA = 1'b0;
		doneW = 1'b0;
		hitB = 1'b0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!hitB) begin
			@(negedge clk);
			bump(n);
			hitA = s_axi_awready && !doneA;
			hitW = s_axi_wready && !doneW;
			hitB = s_axi_bvalid && doneA && doneW;
			resp = s_axi_bresp;
			@(posedge clk);
			if (hitA) s_axi_awvalid <= 1'b0;
			if (hitW) s_axi_wvalid <= 1'b0;
			doneA = doneA || hitA;
			doneW = doneW || hitW;
		end
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic regRead(input logic [11:0] a);
		logic hitA, hitR, doneA;
		int n;
		doneA = 1'b0;
		hitR = 1'b0;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!hitR) begin
			@(negedge clk);
			bump(n);
			hitA = s_axi_arready && !doneA;
			hitR = s_axi_rvalid && doneA;
			rd = s_axi_rdata[7:0];
			resp = s_axi_rresp;
			@(posedge clk);
			if (hitA) s_axi_arvalid <= 1'b0;
			doneA = doneA || hitA;
		end
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic expect8(input logic [11:0] a, input logic [7:0] e);
		regRead(a);
		check(rd, e);
	endtask
	task automatic waitFlag(input int b);
		int n;
		n = 0;
		regRead(tmr_pkg::ADDR_CONTROL);
		while (rd[b] !== 1'b1) begin
			bump(n);
			regRead(tmr_pkg::ADDR_CONTROL);
		end
	endtask
	task automatic pulse();
		compReq <= 1'b1;
		repeat (10) @(posedge clk);
		compReq <= 1'b0;
		repeat (10) @(posedge clk);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		int n, edges;
		logic prev;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		expect8(tmr_pkg::ADDR_CONTROL, 8'h00);
		expect8(tmr_pkg::ADDR_COUNT_HIGH, 8'h00);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h02);
		check({6'h00, resp}, {6'h00, tmr_pkg::RESP_OKAY});
		expect8(tmr_pkg::ADDR_CONTROL, 8'h00);
		regRead(12'h000);
		check({6'h00, resp}, {6'h00, tmr_pkg::RESP_SLVERR});
		regWrite(12'h000, 8'hFF);
		check({6'h00, resp}, {6'h00, tmr_pkg::RESP_SLVERR});
		$display("Test registers done");
		regWrite(tmr_pkg::ADDR_INTERRUPT_ENABLE, 8'h01);
		regWrite(tmr_pkg::ADDR_CLOCK_CONTROL, 8'h01);
		regWrite(tmr_pkg::ADDR_RELOAD_HIGH, 8'h12);
		regWrite(tmr_pkg::ADDR_RELOAD_LOW, 8'h34);
		regWrite(tmr_pkg::ADDR_COUNT_HIGH, 8'hFF);
		regWrite(tmr_pkg::ADDR_COUNT_LOW, 8'hF0);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h04);
		waitFlag(7);
		check(rd, 8'hC4);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'hC0);
		expect8(tmr_pkg::ADDR_CONTROL, 8'hC0);
		expect8(tmr_pkg::ADDR_COUNT_HIGH, 8'h12);
		check({7'h00, timerIrq}, 8'h01);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h00);
		check({7'h00, timerIrq}, 8'h00);
		regWrite(tmr_pkg::ADDR_COUNT_HIGH, 8'h00);
		regWrite(tmr_pkg::ADDR_COUNT_LOW, 8'hF8);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h24);
		waitFlag(6);
		check(rd, 8'h64);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h60);
		expect8(tmr_pkg::ADDR_CONTROL, 8'h60);
		check({7'h00, timerIrq}, 8'h01);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h00);
		$display("Test 16-bit mode done");
		regWrite(tmr_pkg::ADDR_CLOCK_CONTROL, 8'h02);
		regWrite(tmr_pkg::ADDR_RELOAD_LOW, 8'hF0);
		regWrite(tmr_pkg::ADDR_RELOAD_HIGH, 8'h80);
		regWrite(tmr_pkg::ADDR_COUNT_LOW, 8'hFC);
		regWrite(tmr_pkg::ADDR_COUNT_HIGH, 8'hFE);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h08);
		waitFlag(6);
		expect8(tmr_pkg::ADDR_CONTROL, 8'h48);
		expect8(tmr_pkg::ADDR_COUNT_HIGH, 8'hFE);
		check({7'h00, timerIrq}, 8'h00);
		regRead(tmr_pkg::ADDR_COUNT_LOW);
		check({rd[7:4], 4'h0}, 8'hF0);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h4C);
		waitFlag(7);
		check(rd, 8'hCC);
		regRead(tmr_pkg::ADDR_COUNT_HIGH);
		check({rd[7], 7'h00}, 8'h80);
		check({7'h00, timerIrq}, 8'h01);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h00);
		regWrite(tmr_pkg::ADDR_CLOCK_CONTROL, 8'h00);
		regWrite(tmr_pkg::ADDR_COUNT_LOW, 8'h00);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h09);
		oscEn <= 1'b1;
		n = 0;
		edges = 0;
		prev = 1'b0;
		while (edges < 16) begin
			@(posedge clk);
			bump(n);
			if (extOsc && !prev) edges++;
			prev = extOsc;
		end
		oscEn <= 1'b0;
		repeat (10) @(posedge clk);
		expect8(tmr_pkg::ADDR_COUNT_LOW, 8'h02);
		$display("Test split mode done");
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h00);
		regWrite(tmr_pkg::ADDR_CLOCK_CONTROL, 8'h00);
		regWrite(tmr_pkg::ADDR_RELOAD_HIGH, 8'h55);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h18);
		pulse();
		expect8(tmr_pkg::ADDR_RELOAD_HIGH, 8'h55);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h00);
		regWrite(tmr_pkg::ADDR_COUNT_HIGH, 8'h00);
		regWrite(tmr_pkg::ADDR_COUNT_LOW, 8'h00);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h15);
		repeat (80) @(posedge clk);
		pulse();
		waitFlag(7);
		check(rd, 8'h95);
		regWrite(tmr_pkg::ADDR_CONTROL, 8'h90);
		expect8(tmr_pkg::ADDR_RELOAD_HIGH, 8'h00);
		regRead(tmr_pkg::ADDR_RELOAD_LOW);
		check({7'h00, rd > 8'h04 && rd < 8'h30}, 8'h01);
		check({7'h00, timerIrq}, 8'h01);
		$display("Test capture done");
		end_of_test();
	end
endmodule

/* pkg/tick_if.sv */
/*
 Tick carrier between the tick generator and the timer core.
 Both ticks are one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
interface tick_if;
	logic div12Tick;
	logic extTick;
	modport gen (output div12Tick, output extTick);
	modport use_side (input div12Tick, input extTick);
endinterface

/* pkg/tmr_pkg.sv */
/*
 Shared constants for the auto-reload timer with capture: register byte addresses,
 control bit positions, reset values, divider counts, bus responses and modes.
 Assumes a 32-bit AXI4-Lite bus with a 12-bit byte address.
*/
package tmr_pkg;
	// ----------------------------------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [9:0] IDX_CONTROL = 10'h0C8;
	localparam logic [9:0] IDX_RELOAD_LOW = 10'h0CA;
	localparam logic [9:0] IDX_RELOAD_HIGH = 10'h0CB;
	localparam logic [9:0] IDX_COUNT_LOW = 10'h0CC;
	localparam logic [9:0] IDX_COUNT_HIGH = 10'h0CD;
	localparam logic [9:0] IDX_CLOCK_CONTROL = 10'h0D0;
	localparam logic [9:0] IDX_INTERRUPT_ENABLE = 10'h0D1;
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
	localparam logic [11:0] ADDR_RELOAD_LOW = {IDX_RELOAD_LOW, 2'b00};
	localparam logic [11:0] ADDR_RELOAD_HIGH = {IDX_RELOAD_HIGH, 2'b00};
	localparam logic [11:0] ADDR_COUNT_LOW = {IDX_COUNT_LOW, 2'b00};
	localparam logic [11:0] ADDR_COUNT_HIGH = {IDX_COUNT_HIGH, 2'b00};
	localparam logic [11:0] ADDR_CLOCK_CONTROL = {IDX_CLOCK_CONTROL, 2'b00};
	localparam logic [11:0] ADDR_INTERRUPT_ENABLE = {IDX_INTERRUPT_ENABLE, 2'b00};
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int BIT_HIGH_FLAG = 7;
	localparam int BIT_LOW_FLAG = 6;
	localparam int BIT_LOW_IRQ_EN = 5;
	localparam int BIT_CAPTURE_EN = 4;
	localparam int BIT_SPLIT = 3;
	localparam int BIT_RUN = 2;
	localparam int BIT_EXT_CLK = 0;
	localparam int BIT_LOW_SEL = 0;
	localparam int BIT_HIGH_SEL = 1;
	localparam int BIT_TIMER_IRQ_EN = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hFF;
	// ----------------------------------------------------------------
	// Tick dividers and bus answers
	// ----------------------------------------------------------------
	localparam int SYS_DIV = 12;
	localparam int EXT_DIV = 8;
	localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
	localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		MODE_AUTO16 = 3'h1,
		MODE_SPLIT = 3'h2,
		MODE_CAPTURE = 3'h4
	} mode_t;
endpackage

/* rtl/autoreload_timer_with_capture.sv */
/*
 Auto-reload timer with comparator capture, 16-bit or split 8-bit, AXI4-Lite slave.
 Assumes comparatorOut and extOsc are asynchronous; the bus master keeps AXI4-Lite rules.
*/
// Added by the designer: register access over AXI4-Lite.
// How it works
// - 16-bit mode: on wrap from all ones, load reload value, set high flag.
// - Control bit 3 picks one 16-bit counter or two 8-bit counters.
// - Timer interrupt enabled: every 16-bit overflow raises the interrupt.
// - 16-bit mode with low interrupt enable: low byte wrap also interrupts.
// - Split mode: each half reloads from its own reload byte on wrap.
// - Split mode: run bit gates only the high half; low always counts.
// - Per-half select: 1 system clock, 0 divide-by-12 or external divide-by-8.
// - External divide-by-8 tick is synchronised before advancing any counter.
// - Split mode: high wrap sets high flag, low wrap sets low flag.
// - Low byte wrap sets the low flag in every mode.
// - Split mode interrupts on high wrap, or either wrap with low enable.
// - Capture mode only with capture enable set and split cleared.
// - Comparator rising edge copies count to reload, sets high flag.
// - Capture mode ticks from system clock or divide-by-12 only.
// - Control register holds flags, enables, mode, run, clock select; resets zero.
// - Run bit set enables counting; split mode affects only the high half.
// - Control bit 1 reads zero and ignores writes.
`timescale 1ns/1ps
module autoreload_timer_with_capture (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic extOsc,
	input wire logic comparatorOut,
	output logic timerIrq,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic highFlag;
	logic lowFlag;
	logic lowIrqEnable;
	logic captureEnable;
	logic splitMode;
	logic runControl;
	logic extClockSelect;
	logic lowHalfClockSelect;
	logic highHalfClockSelect;
	logic timerIrqEnable;
	logic [7:0] countLow;
	logic [7:0] countHigh;
	logic [7:0] reloadLow;
	logic [7:0] reloadHigh;
	logic compMeta;
	logic compSync;
	logic compDelay;
	logic [11:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic [7:0] next_countLow;
	logic [7:0] next_countHigh;
	logic setHigh;
	logic setLow;
	tmr_pkg::mode_t mode;
	tick_if ticks ();

	clock_tick_gen tickGen (
		.clk(clk),
		.sys_rst(sys_rst),
		.extOsc(extOsc),
		.ticks(ticks.gen)
	);

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	function automatic logic regHit(input logic [11:0] addr, input logic [11:0] target);
		regHit = (addr[11:2] == target[11:2]);
	endfunction

	function automatic logic selectTick(input logic sel, input logic xclk,
		input logic div12, input logic ext);
		selectTick = sel ? 1'b1 : (xclk ? ext : div12);
	endfunction

	wire doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire lane0 = doWrite && wStrb[0];
	wire wrControl = lane0 && regHit(awAddr, tmr_pkg::ADDR_CONTROL);
	wire wrReloadLow = lane0 && regHit(awAddr, tmr_pkg::ADDR_RELOAD_LOW);
	wire wrReloadHigh = lane0 && regHit(awAddr, tmr_pkg::ADDR_RELOAD_HIGH);
	wire wrCountLow = lane0 && regHit(awAddr, tmr_pkg::ADDR_COUNT_LOW);
	wire wrCountHigh = lane0 && regHit(awAddr, tmr_pkg::ADDR_COUNT_HIGH);
	wire wrClockControl = lane0 && regHit(awAddr, tmr_pkg::ADDR_CLOCK_CONTROL);
	wire wrIrqEnable = lane0 && regHit(awAddr, tmr_pkg::ADDR_INTERRUPT_ENABLE);
	wire writeMapped = regHit(awAddr, tmr_pkg::ADDR_CONTROL)
		|| regHit(awAddr, tmr_pkg::ADDR_RELOAD_LOW) || regHit(awAddr, tmr_pkg::ADDR_RELOAD_HIGH)
		|| regHit(awAddr, tmr_pkg::ADDR_COUNT_LOW) || regHit(awAddr, tmr_pkg::ADDR_COUNT_HIGH)
		|| regHit(awAddr, tmr_pkg::ADDR_CLOCK_CONTROL)
		|| regHit(awAddr, tmr_pkg::ADDR_INTERRUPT_ENABLE);

	wire [7:0] controlValue = {highFlag, lowFlag, lowIrqEnable, captureEnable,
		splitMode, runControl, 1'b0, extClockSelect};
	wire [7:0] clockControlValue = {6'h00, highHalfClockSelect, lowHalfClockSelect};
	wire [7:0] irqEnableValue = {7'h00, timerIrqEnable};
	wire hitControl = regHit(s_axi_araddr, tmr_pkg::ADDR_CONTROL);
	wire hitReloadLow = regHit(s_axi_araddr, tmr_pkg::ADDR_RELOAD_LOW);
	wire hitReloadHigh = regHit(s_axi_araddr, tmr_pkg::ADDR_RELOAD_HIGH);
	wire hitCountLow = regHit(s_axi_araddr, tmr_pkg::ADDR_COUNT_LOW);
	wire hitCountHigh = regHit(s_axi_araddr, tmr_pkg::ADDR_COUNT_HIGH);
	wire hitClockControl = regHit(s_axi_araddr, tmr_pkg::ADDR_CLOCK_CONTROL);
	wire hitIrqEnable = regHit(s_axi_araddr, tmr_pkg::ADDR_INTERRUPT_ENABLE);
	wire readMapped = hitControl || hitReloadLow || hitReloadHigh || hitCountLow
		|| hitCountHigh || hitClockControl || hitIrqEnable;
	wire [7:0] readByte = hitControl ? controlValue :
		hitReloadLow ? reloadLow :
		hitReloadHigh ? reloadHigh :
		hitCountLow ? countLow :
		hitCountHigh ? countHigh :
		hitClockControl ? clockControlValue :
		hitIrqEnable ? irqEnableValue : 8'h00;

	// ----------------------------------------------------------------
	// Mode, ticks and capture edge
	// ----------------------------------------------------------------
	assign mode = splitMode ? tmr_pkg::MODE_SPLIT :
		(captureEnable ? tmr_pkg::MODE_CAPTURE : tmr_pkg::MODE_AUTO16);
	wire xclkEff = extClockSelect && (mode != tmr_pkg::MODE_CAPTURE);
	wire lowTick = selectTick(lowHalfClockSelect, xclkEff,
		ticks.div12Tick, ticks.extTick);
	wire highTick = selectTick(highHalfClockSelect, xclkEff,
		ticks.div12Tick, ticks.extTick);
	wire compRise = compSync && !compDelay;
	wire captureEvt = compRise && (mode == tmr_pkg::MODE_CAPTURE);
	wire [15:0] count16 = {countHigh, countLow};
	wire [15:0] count16Inc = count16 + 16'h0001;
	wire irqCause = highFlag || (lowIrqEnable && lowFlag);

	// ----------------------------------------------------------------
	// Counter next state
	// ----------------------------------------------------------------
	always_comb begin
		next_countLow = countLow;
		next_countHigh = countHigh;
		setHigh = 1'b0;
		setLow = 1'b0;
		unique case (mode)
			tmr_pkg::MODE_AUTO16, tmr_pkg::MODE_CAPTURE: begin
				if (runControl && lowTick) begin
					setLow = (countLow == tmr_pkg::BYTE_ONES);
					if (count16 == 16'hFFFF) begin
						next_countLow = reloadLow;
						next_countHigh = reloadHigh;
						setHigh = 1'b1;
					end else begin
						next_countLow = count16Inc[7:0];
						next_countHigh = count16Inc[15:8];
					end
				end
			end
			tmr_pkg::MODE_SPLIT: begin
				if (lowTick) begin
					setLow = (countLow == tmr_pkg::BYTE_ONES);
					next_countLow = setLow ? reloadLow : countLow + 8'h01;
				end
				if (runControl && highTick) begin
					setHigh = (countHigh == tmr_pkg::BYTE_ONES);
					next_countHigh = setHigh ? reloadHigh : countHigh + 8'h01;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Timer registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{highFlag, lowFlag, lowIrqEnable, captureEnable} <= tmr_pkg::CONTROL_RESET[7:4];
			{splitMode, runControl, extClockSelect} <= 3'h0;
			lowHalfClockSelect <= 1'b0;
			highHalfClockSelect <= 1'b0;
			timerIrqEnable <= 1'b0;
			countLow <= tmr_pkg::BYTE_RESET;
			countHigh <= tmr_pkg::BYTE_RESET;
			reloadLow <= tmr_pkg::BYTE_RESET;
			reloadHigh <= tmr_pkg::BYTE_RESET;
			compMeta <= 1'b0;
			compSync <= 1'b0;
			compDelay <= 1'b0;
			timerIrq <= 1'b0;
		end else begin
			compMeta <= comparatorOut;
			compSync <= compMeta;
			compDelay <= compSync;
			timerIrq <= timerIrqEnable && irqCause;
			highFlag <= (wrControl ? wData[tmr_pkg::BIT_HIGH_FLAG] : highFlag)
				|| setHigh || captureEvt;
			lowFlag <= (wrControl ? wData[tmr_pkg::BIT_LOW_FLAG] : lowFlag) || setLow;
			if (wrControl) begin
				lowIrqEnable <= wData[tmr_pkg::BIT_LOW_IRQ_EN];
				captureEnable <= wData[tmr_pkg::BIT_CAPTURE_EN];
				splitMode <= wData[tmr_pkg::BIT_SPLIT];
				runControl <= wData[tmr_pkg::BIT_RUN];
				extClockSelect <= wData[tmr_pkg::BIT_EXT_CLK];
			end
			if (wrClockControl) begin
				lowHalfClockSelect <= wData[tmr_pkg::BIT_LOW_SEL];
				highHalfClockSelect <= wData[tmr_pkg::BIT_HIGH_SEL];
			end
			if (wrIrqEnable) begin
				timerIrqEnable <= wData[tmr_pkg::BIT_TIMER_IRQ_EN];
			end
			countLow <= wrCountLow ? wData[7:0] : next_countLow;
			countHigh <= wrCountHigh ? wData[7:0] : next_countHigh;
			if (captureEvt) begin
				reloadLow <= countLow;
				reloadHigh <= countHigh;
			end else begin
				if (wrReloadLow) begin
					reloadLow <= wData[7:0];
				end
				if (wrReloadHigh) begin
					reloadHigh <= wData[7:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tmr_pkg::RESP_OKAY;
			awAddr <= 12'h000;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= writeMapped ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= tmr_pkg::RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, readByte};
				s_axi_rresp <= readMapped ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_wrap16;
		!splitMode && runControl && lowTick && (count16 == 16'hFFFF)
			&& !wrCountLow && !wrCountHigh;
	endsequence
	sequence s_lowWrap;
		lowTick && (countLow == tmr_pkg::BYTE_ONES) && !wrCountLow
			&& (splitMode || runControl);
	endsequence

	property p_wrap16;
		s_wrap16 |=> (count16 == {$past(reloadHigh), $past(reloadLow)}) && highFlag;
	endproperty
	a_wrap16: assert property (p_wrap16) else $error("16-bit wrap did not reload");
	property p_irqOnFlag;
		timerIrqEnable && highFlag |=> timerIrq;
	endproperty
	a_irqOnFlag: assert property (p_irqOnFlag) else $error("irq missing on high flag");
	property p_irqLow;
		timerIrqEnable && lowIrqEnable && lowFlag |=> timerIrq;
	endproperty
	a_irqLow: assert property (p_irqLow) else $error("irq missing on low flag");
	property p_irqMasked;
		!timerIrqEnable || (!highFlag && !(lowIrqEnable && lowFlag)) |=> !timerIrq;
	endproperty
	a_irqMasked: assert property (p_irqMasked) else $error("irq without cause");
	property p_lowWrap;
		s_lowWrap |=> lowFlag;
	endproperty
	a_lowWrap: assert property (p_lowWrap) else $error("low wrap did not set flag");
	property p_splitLowReload;
		(splitMode and s_lowWrap) |=> countLow == $past(reloadLow);
	endproperty
	a_splitLowReload: assert property (p_splitLowReload) else $error("low half reload");
	property p_splitLowFree;
		splitMode && lowTick && (countLow != tmr_pkg::BYTE_ONES) && !wrCountLow
			|=> countLow == $past(countLow) + 8'h01;
	endproperty
	a_splitLowFree: assert property (p_splitLowFree) else $error("low half not counting");
	property p_splitHighStop;
		splitMode && !runControl && !wrCountHigh |=> $stable(countHigh);
	endproperty
	a_splitHighStop: assert property (p_splitHighStop) else $error("high half ran");
	property p_splitHighWrap;
		splitMode && runControl && highTick && (countHigh == tmr_pkg::BYTE_ONES) && !wrCountHigh
			|=> highFlag && (countHigh == $past(reloadHigh));
	endproperty
	a_splitHighWrap: assert property (p_splitHighWrap) else $error("high half wrap");
	property p_capture;
		captureEvt |=> highFlag && ({reloadHigh, reloadLow} == $past(count16));
	endproperty
	a_capture: assert property (p_capture) else $error("capture not taken");
	property p_noCaptureSplit;
		splitMode && !wrReloadLow |=> $stable(reloadLow);
	endproperty
	a_noCaptureSplit: assert property (p_noCaptureSplit) else $error("capture in split");
	property p_captureNoExt;
		(mode == tmr_pkg::MODE_CAPTURE) && !lowHalfClockSelect |-> lowTick == ticks.div12Tick;
	endproperty
	a_captureNoExt: assert property (p_captureNoExt) else $error("capture used ext tick");
endmodule

/* rtl/clock_tick_gen.sv */
/*
 Tick generator: system clock divided by 12, and external oscillator divided by 8.
 Assumes extOsc is asynchronous to clk and slower than half the clk rate.
*/
`timescale 1ns/1ps
module clock_tick_gen (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic extOsc,
	tick_if.gen ticks
);
	logic [3:0] sysCount;
	logic extMeta;
	logic extSync;
	logic extDelay;
	logic [2:0] extCount;
	wire extRise = extSync && !extDelay;

	// ----------------------------------------------------------------
	// Dividers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sysCount <= 4'h0;
			ticks.div12Tick <= 1'b0;
		end else begin
			ticks.div12Tick <= (sysCount == tmr_pkg::SYS_DIV_LAST);
			sysCount <= (sysCount == tmr_pkg::SYS_DIV_LAST) ? 4'h0 : sysCount + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			extMeta <= 1'b0;
			extSync <= 1'b0;
			extDelay <= 1'b0;
			extCount <= 3'h0;
			ticks.extTick <= 1'b0;
		end else begin
			extMeta <= extOsc;
			extSync <= extMeta;
			extDelay <= extSync;
			ticks.extTick <= extRise && (extCount == tmr_pkg::EXT_DIV_LAST);
			if (extRise) begin
				extCount <= extCount + 3'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_div12Gap;
		!ticks.div12Tick [*8] ##1 !ticks.div12Tick [*3] ##1 ticks.div12Tick;
	endsequence
	property p_div12Period;
		@(posedge clk) disable iff (sys_rst) ticks.div12Tick |=> s_div12Gap;
	endproperty
	a_div12Period: assert property (p_div12Period) else $error("div12 tick period wrong");
	property p_extFromEdge;
		@(posedge clk) disable iff (sys_rst)
		ticks.extTick |-> $past(extRise) && ($past(extCount) == tmr_pkg::EXT_DIV_LAST);
	endproperty
	a_extFromEdge: assert property (p_extFromEdge) else $error("ext tick not from edge");
endmodule
